// ### rtl/afepg_ctrl.v
/*
 afepg_ctrl.v: serial port enable, clock derivation, control registers and
 per-channel gain selection of a six-channel sampling front end, with its
 sample fifo. assumes all inputs synchronous to core_clk_in except
 port_enable_in, and a host that wires frame syncs as it chooses.
*/
// What this block does
// - outputs three-stated while port enable low
// - serial inputs ignored while port enable low
// - serial clock stopped while port enable low
// - control and data registers survive disable
// - serial counters and port state reset on disable
// - enable accepted without clock relation
// - eight 8-bit read/write control registers
// - internal master clock divided from master
// - gain stage sampled at internal clock/8
// - gain code maps to eight dB steps
// - gain fields in fourth to sixth registers
// - sample register updated at programmed rate
// - frame sync one period before msb
// - inputs sampled falling, data out rising
// - chip reset clears registers and logic
`timescale 1ns/1ns
`include "afepg_defines.vh"

module afepg_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q, rd_q;
	reg [AW:0] cnt_q;
	wire push, pop;
	assign in_ready_out = (cnt_q != DEPTH[AW:0]);
	assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
	assign out_data_out = mem[rd_q];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	always @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_q] <= in_data_in;
		end
	end
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // afepg_fifo

module afepg_ctrl #(
	parameter [7:0] MCLK_DIV = `AFEPG_MCLK_DIV,
	parameter [7:0] SCLK_HALF = `AFEPG_SCLK_HALF,
	parameter FIFO_DEPTH = `AFEPG_FIFO_DEPTH
) (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire port_enable_in,
	input wire serial_data_in,
	input wire in_frame_sync_in,
	input wire [15:0] adc_word_in,
	output wire sclk_out,
	output wire serial_data_out,
	output wire serial_data_oe_out,
	output wire out_frame_sync_out,
	output wire out_frame_sync_oe_out,
	output wire internal_master_clock_tick_out,
	output wire sc_sample_tick_out,
	output wire sample_tick_out,
	output wire adc_ready_out,
	output wire [17:0] chan_gain_code_out,
	output wire [35:0] chan_gain_db_out
);
	localparam TX_IDLE = 2'h0;
	localparam TX_FS = 2'h1;
	localparam TX_SHIFT = 2'h2;
	localparam RX_IDLE = 1'b0;
	localparam RX_SHIFT = 1'b1;
	function [5:0] afepg_db;
		input [2:0] code;
		begin
			case (code)
				3'h0: afepg_db = 6'h00;
				3'h1: afepg_db = 6'h06;
				3'h2: afepg_db = 6'h0c;
				3'h3: afepg_db = 6'h12;
				3'h4: afepg_db = 6'h14;
				3'h5: afepg_db = 6'h1a;
				3'h6: afepg_db = 6'h20;
				3'h7: afepg_db = 6'h26;
				default: afepg_db = 6'h00;
			endcase
		end
	endfunction
	reg pe_meta_q, pe_sync_q, dm_tick_q, sc_tick_q, rate_tick_q, sclk_q;
	reg sample_pend_q, sdo_q, fs_q, rx_st_q, rb_pend_q;
	reg [7:0] dm_cnt_q, sclk_cnt_q;
	reg [3:0] sc_cnt_q, rx_cnt_q;
	reg [10:0] rate_cnt_q;
	reg [7:0] ctrl_q [0:`AFEPG_NUM_REGS-1];
	reg [15:0] sample_q, tx_shift_q, rx_shift_q, rb_word_q;
	reg [1:0] tx_st_q;
	reg [4:0] tx_cnt_q;
	reg [35:0] db_q;
	wire port_on, sclk_rise, sclk_fall, fifo_valid, fifo_pop, rx_done, rb_set, rb_take;
	wire [15:0] fifo_data, rx_word;
	wire [10:0] rate_top;
	integer i;
	// enable synchroniser; oe also gated by the raw pin
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pe_meta_q <= 1'b0;
			pe_sync_q <= 1'b0;
		end else begin
			pe_meta_q <= port_enable_in;
			pe_sync_q <= pe_meta_q;
		end
	end
	assign port_on = pe_sync_q & port_enable_in;
	// internal master clock, sc and sample rate ticks
	assign rate_top = (`AFEPG_RATE_BASE << (2'h3 - ctrl_q[`AFEPG_REG_RATE][1:0])) |
		((11'h001 << (2'h3 - ctrl_q[`AFEPG_REG_RATE][1:0])) - 11'h001);
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dm_cnt_q <= 8'h00;
			dm_tick_q <= 1'b0;
			sc_cnt_q <= 4'h0;
			sc_tick_q <= 1'b0;
			rate_cnt_q <= 11'h000;
			rate_tick_q <= 1'b0;
		end else begin
			dm_tick_q <= (dm_cnt_q == MCLK_DIV - 8'h01);
			dm_cnt_q <= (dm_cnt_q == MCLK_DIV - 8'h01) ? 8'h00 : dm_cnt_q + 8'h01;
			sc_tick_q <= 1'b0;
			rate_tick_q <= 1'b0;
			if (dm_tick_q) begin
				sc_tick_q <= (sc_cnt_q == `AFEPG_SC_DIV - 4'h1);
				sc_cnt_q <= (sc_cnt_q == `AFEPG_SC_DIV - 4'h1) ? 4'h0 : sc_cnt_q + 4'h1;
				rate_tick_q <= (rate_cnt_q >= rate_top);
				rate_cnt_q <= (rate_cnt_q >= rate_top) ? 11'h000 : rate_cnt_q + 11'h001;
			end
		end
	end
	// serial clock from internal clock, halted while disabled
	assign sclk_rise = dm_tick_q & port_on & ~sclk_q & (sclk_cnt_q == SCLK_HALF - 8'h01);
	assign sclk_fall = dm_tick_q & port_on & sclk_q & (sclk_cnt_q == SCLK_HALF - 8'h01);
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sclk_cnt_q <= 8'h00;
			sclk_q <= 1'b0;
		end else if (!port_on) begin
			sclk_cnt_q <= 8'h00;
			sclk_q <= 1'b0;
		end else if (dm_tick_q) begin
			if (sclk_cnt_q == SCLK_HALF - 8'h01) begin
				sclk_cnt_q <= 8'h00;
				sclk_q <= ~sclk_q;
			end else begin
				sclk_cnt_q <= sclk_cnt_q + 8'h01;
			end
		end
	end
	// sample register and fifo feed
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sample_q <= 16'h0000;
			sample_pend_q <= 1'b0;
		end else begin
			if (rate_tick_q) begin
				sample_q <= adc_word_in;
			end
			sample_pend_q <= rate_tick_q | (sample_pend_q & ~adc_ready_out);
		end
	end
	afepg_fifo #(
		.WIDTH(`AFEPG_WORD_W),
		.DEPTH(FIFO_DEPTH),
		.AW(4)
	) u_fifo (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.in_valid_in(sample_pend_q),
		.in_ready_out(adc_ready_out),
		.in_data_in(sample_q),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_data)
	);
	// transmit: frame sync, then 16 bits msb first on rising edges
	assign rb_take = sclk_rise & (tx_st_q == TX_IDLE) & rb_pend_q;
	assign fifo_pop = sclk_rise & (tx_st_q == TX_IDLE) & ~rb_pend_q & fifo_valid;
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_st_q <= TX_IDLE;
			tx_cnt_q <= 5'h00;
			tx_shift_q <= 16'h0000;
			sdo_q <= 1'b0;
			fs_q <= 1'b0;
		end else if (!port_on) begin
			tx_st_q <= TX_IDLE;
			tx_cnt_q <= 5'h00;
			fs_q <= 1'b0;
		end else if (sclk_rise) begin
			case (tx_st_q)
				TX_IDLE: begin
					if (rb_pend_q | fifo_valid) begin
						tx_shift_q <= rb_pend_q ? rb_word_q : fifo_data;
						fs_q <= 1'b1;
						tx_st_q <= TX_FS;
					end
				end
				TX_FS: begin
					fs_q <= 1'b0;
					sdo_q <= tx_shift_q[15];
					tx_shift_q <= {tx_shift_q[14:0], 1'b0};
					tx_cnt_q <= 5'h0f;
					tx_st_q <= TX_SHIFT;
				end
				TX_SHIFT: begin
					if (tx_cnt_q != 5'h00) begin
						sdo_q <= tx_shift_q[15];
						tx_shift_q <= {tx_shift_q[14:0], 1'b0};
						tx_cnt_q <= tx_cnt_q - 5'h01;
					end else begin
						tx_st_q <= TX_IDLE;
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end
	assign sclk_out = sclk_q;
	assign serial_data_out = sdo_q;
	assign serial_data_oe_out = port_on & (tx_st_q == TX_SHIFT);
	assign out_frame_sync_out = fs_q;
	assign out_frame_sync_oe_out = port_on;
	// receive on falling edges, host frames its own words
	assign rx_word = {rx_shift_q[14:0], serial_data_in};
	assign rx_done = sclk_fall & (rx_st_q == RX_SHIFT) & (rx_cnt_q == 4'hf);
	assign rb_set = rx_done & ~rx_word[`AFEPG_CMD_WR_BIT];
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 4'h0;
			rx_shift_q <= 16'h0000;
		end else if (!port_on) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 4'h0;
		end else if (sclk_fall) begin
			case (rx_st_q)
				RX_IDLE: begin
					if (in_frame_sync_in) begin
						rx_st_q <= RX_SHIFT;
						rx_cnt_q <= 4'h0;
					end
				end
				RX_SHIFT: begin
					rx_shift_q <= rx_word;
					rx_cnt_q <= rx_cnt_q + 4'h1;
					if (rx_cnt_q == 4'hf) begin
						rx_st_q <= RX_IDLE;
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// control registers, kept across disable; read answers queued for tx
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (i = 0; i < `AFEPG_NUM_REGS; i = i + 1) begin
				ctrl_q[i] <= `AFEPG_REG_RESET;
			end
			rb_word_q <= 16'h0000;
			rb_pend_q <= 1'b0;
			db_q <= 36'h000000000;
		end else begin
			if (rx_done & rx_word[`AFEPG_CMD_WR_BIT]) begin
				ctrl_q[rx_word[10:8]] <= rx_word[7:0];
			end
			if (rb_set) begin
				rb_word_q <= {5'h00, rx_word[10:8], ctrl_q[rx_word[10:8]]};
			end
			if (!port_on) begin
				rb_pend_q <= 1'b0;
			end else begin
				rb_pend_q <= rb_set | (rb_pend_q & ~rb_take);
			end
			for (i = 0; i < `AFEPG_NUM_CHAN; i = i + 1) begin
				db_q[i*6 +: 6] <= afepg_db(chan_gain_code_out[i*3 +: 3]);
			end
		end
	end

	// two channels per gain register, registers three to five
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_gain
			assign chan_gain_code_out[g*6 +: 3] =
				ctrl_q[`AFEPG_REG_GAIN0 + g][`AFEPG_GAIN_LO_LSB +: 3];
			assign chan_gain_code_out[g*6+3 +: 3] =
				ctrl_q[`AFEPG_REG_GAIN0 + g][`AFEPG_GAIN_HI_LSB +: 3];
		end
	endgenerate
	assign chan_gain_db_out = db_q;
	assign internal_master_clock_tick_out = dm_tick_q;
	assign sc_sample_tick_out = sc_tick_q;
	assign sample_tick_out = rate_tick_q;
endmodule // afepg_ctrl

// ### rtl/afepg_defines.vh
/*
 afepg_defines.vh: constants of the port enable and gain control block.
 assumes inclusion by bare name from the design file.
*/
`ifndef AFEPG_DEFINES_VH
`define AFEPG_DEFINES_VH
`define AFEPG_NUM_REGS 8
`define AFEPG_NUM_CHAN 6
`define AFEPG_WORD_W 16
`define AFEPG_MCLK_DIV 8'h01
`define AFEPG_SCLK_HALF 8'h04
`define AFEPG_SC_DIV 4'h8
`define AFEPG_FIFO_DEPTH 16
`define AFEPG_REG_RATE 3'h1
`define AFEPG_REG_GAIN0 3'h3
`define AFEPG_RATE_LSB 0
`define AFEPG_GAIN_LO_LSB 0
`define AFEPG_GAIN_HI_LSB 4
`define AFEPG_CMD_WR_BIT 15
`define AFEPG_CMD_ADDR_LSB 8
`define AFEPG_REG_RESET 8'h00
`define AFEPG_RATE_BASE 11'h0ff
`endif

// ### sim/afepg_properties.sv
/* afepg_properties.sv: port timing and gain checks of afepg_ctrl.
 assumes a bind to afepg_ctrl and one clock domain. */
`timescale 1ns/1ns
module afepg_props #(
	parameter [7:0] MCLK_DIV = 8'h01,
	parameter [7:0] SCLK_HALF = 8'h04
) (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire port_enable_in,
	input wire sclk_out,
	input wire serial_data_out,
	input wire serial_data_oe_out,
	input wire out_frame_sync_out,
	input wire out_frame_sync_oe_out,
	input wire internal_master_clock_tick_out,
	input wire sc_sample_tick_out,
	input wire [17:0] chan_gain_code_out,
	input wire [35:0] chan_gain_db_out
);
	logic [15:0] d_gap, s_gap, fs_len, oe_len;
	logic d_seen, s_seen;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	function automatic [35:0] db_all(input [17:0] c);
		integer i;
		for (i = 0; i < 6; i++) db_all[6*i+:6] = c[3*i+:2] * 6 + c[3*i+2] * 20;
	endfunction
	// gaps between ticks, lengths of fs and data
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			{d_gap, s_gap, fs_len, oe_len} <= 64'h0;
			{d_seen, s_seen} <= 2'h0;
		end else begin
			d_gap <= internal_master_clock_tick_out ? 16'h1 : d_gap + 16'h1;
			s_gap <= sc_sample_tick_out ? 16'h1 : s_gap + 16'h1;
			fs_len <= out_frame_sync_out ? fs_len + 16'h1 : 16'h0;
			oe_len <= serial_data_oe_out ? oe_len + 16'h1 : 16'h0;
			d_seen <= d_seen | internal_master_clock_tick_out;
			s_seen <= s_seen | sc_sample_tick_out;
		end
	end
	oe_off_a: assert property (!port_enable_in |-> !serial_data_oe_out && !out_frame_sync_oe_out)
		else $error("oe high while disabled");
	sclk_stop_a: assert property (!port_enable_in [*4] |-> !sclk_out)
		else $error("sclk runs while disabled");
	enable_sync_a: assert property ($rose(port_enable_in) |-> !sclk_out [*2] ##[1:60] sclk_out)
		else $error("sclk start after enable wrong");
	internal_master_clock_div_a: assert property (internal_master_clock_tick_out && d_seen |-> d_gap == MCLK_DIV)
		else $error("internal_master_clock tick spacing wrong");
	sc_rate_a: assert property (sc_sample_tick_out && s_seen |-> s_gap == 8 * MCLK_DIV)
		else $error("sc tick spacing wrong");
	fs_width_a: assert property ($fell(out_frame_sync_out) && port_enable_in |->
		fs_len == 2 * SCLK_HALF * MCLK_DIV && serial_data_oe_out) else $error("fs width wrong");
	fs_edge_a: assert property ($changed(out_frame_sync_out) && port_enable_in |-> $rose(sclk_out))
		else $error("fs off rising edge");
	sdo_edge_a: assert property (serial_data_oe_out && $changed(serial_data_out) |-> $rose(sclk_out))
		else $error("data off rising edge");
	word_len_a: assert property ($fell(serial_data_oe_out) && port_enable_in |->
		oe_len == 32 * SCLK_HALF * MCLK_DIV) else $error("word length wrong");
	gain_map_a: assert property (1'b1 |=> chan_gain_db_out == db_all($past(chan_gain_code_out)))
		else $error("gain db wrong");
	gain_rst_a: assert property ($rose(rst_b_in) |-> chan_gain_code_out == 18'h0)
		else $error("gain not cleared");
endmodule // afepg_props
bind afepg_ctrl afepg_props #(.MCLK_DIV(MCLK_DIV), .SCLK_HALF(SCLK_HALF)) u_props (.core_clk_in,
	.rst_b_in, .port_enable_in, .sclk_out, .serial_data_out, .serial_data_oe_out,
	.out_frame_sync_out, .out_frame_sync_oe_out, .internal_master_clock_tick_out, .sc_sample_tick_out,
	.chan_gain_code_out, .chan_gain_db_out);

// ### sim/afepg_host.sv
/* afepg_host.sv: behavioural host serial port facing afepg_ctrl.
 assumes split wiring unless LOOPBACK is set. */
`timescale 1ns/1ns
module afepg_host #(
	parameter LOOPBACK = 0
) (
	input wire sclk_in,
	input wire sdo_in,
	input wire fs_in,
	input wire fs_oe_in,
	output wire sdi_out,
	output wire fsi_out
);
	logic sdi_q = 1'b0;
	logic fsi_q = 1'b0;
	logic [15:0] shift_q = 16'h0;
	logic [15:0] rx_word = 16'h0;
	integer rx_cnt = 0;
	integer bits = 0;
	assign sdi_out = sdi_q;
	assign fsi_out = LOOPBACK ? (fs_in & fs_oe_in) : fsi_q;
	// receive on falling sclk, msb first
	always @(negedge sclk_in) begin
		if (fs_oe_in && fs_in) bits = 16;
		else if (bits > 0) begin
			shift_q = {shift_q[14:0], sdo_in};
			bits--;
			if (bits == 0) begin
				rx_word = shift_q;
				rx_cnt++;
			end
		end
	end
	task send(input [15:0] w);
		integer i;
		@(posedge sclk_in) fsi_q <= 1'b1;
		@(posedge sclk_in) fsi_q <= 1'b0;
		sdi_q <= w[15];
		for (i = 14; i >= 0; i--) @(posedge sclk_in) sdi_q <= w[i];
		@(posedge sclk_in) sdi_q <= ~w[0];
	endtask
endmodule // afepg_host

// ### sim/tb.sv
/* tb.sv: self-checking bench of afepg_ctrl with a host model.
 assumes a 100 MHz clock and reset held for 16 cycles. */
`timescale 1ns/1ns
module tb;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic port_enable_in = 1'b0;
	logic [15:0] adc_word_in = 16'hffff;
	wire serial_data_in, in_frame_sync_in, sclk_out, serial_data_out, serial_data_oe_out;
	wire out_frame_sync_out, out_frame_sync_oe_out, adc_ready_out, sample_tick_out;
	wire [17:0] chan_gain_code_out;
	wire [35:0] chan_gain_db_out;
	logic [5:0] db_tab [0:7] = '{6'h00, 6'h06, 6'h0c, 6'h12, 6'h14, 6'h1a, 6'h20, 6'h26};
	integer num_errors = 0;
	integer compares = 0;
	always #5 core_clk_in = ~core_clk_in;
	afepg_ctrl #(.MCLK_DIV(8'h02), .SCLK_HALF(8'h04), .FIFO_DEPTH(16)) dut (.core_clk_in,
		.rst_b_in, .port_enable_in, .serial_data_in, .in_frame_sync_in, .adc_word_in,
		.sclk_out, .serial_data_out, .serial_data_oe_out, .out_frame_sync_out,
		.out_frame_sync_oe_out, .internal_master_clock_tick_out(), .sc_sample_tick_out(), .sample_tick_out,
		.adc_ready_out, .chan_gain_code_out, .chan_gain_db_out);
	afepg_host host (.sclk_in(sclk_out), .sdo_in(serial_data_out), .fs_in(out_frame_sync_out),
		.fs_oe_in(out_frame_sync_oe_out), .sdi_out(serial_data_in), .fsi_out(in_frame_sync_in));
	task chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task report_and_stop;
		if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task wr(input [2:0] a, input [7:0] d);
		host.send({1'b1, 4'h0, a, d});
		cyc(4);
	endtask
	task wait_word;
		integer n, t;
		n = host.rx_cnt;
		for (t = 0; t < 2000 && host.rx_cnt == n; t++) cyc(1);
		chk("word_wait", t < 2000, 1'b1);
	endtask
	task t_gain;
		integer c;
		for (c = 0; c < 8; c++) begin
			wr(3'h3, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
			chk("gain_code", chan_gain_code_out[5:0], {3'(7 - c), 3'(c)});
			chk("gain_db", chan_gain_db_out[11:0], {db_tab[7 - c], db_tab[c]});
		end
		wr(3'h4, 8'h52);
		wr(3'h5, 8'h47);
		chk("gain_all", chan_gain_code_out, 18'h27a87);
		chk("gain_db_all", chan_gain_db_out, {db_tab[4], db_tab[7], db_tab[5], db_tab[2], db_tab[0], db_tab[7]});
	endtask
	task t_read;
		integer k;
		wr(3'h7, 8'ha5);
		host.send(16'h0700);
		for (k = 0; k < 3; k++) begin
			wait_word;
			if (host.rx_word[15:11] === 5'h0) break;
		end
		chk("readback", host.rx_word, 16'h07a5);
	endtask
	task t_rate;
		integer t, r;
		for (r = 2; r < 4; r++) begin
			wr(3'h1, 8'(r));
			@(posedge sample_tick_out);
			@(posedge sample_tick_out);
			t = 0;
			do begin
				cyc(1);
				t++;
			end while (sample_tick_out !== 1'b1 && t < 5000);
			chk("rate_gap", t, 512 << (3 - r));
		end
	endtask
	task t_disable;
		integer t;
		wait_word;
		@(posedge core_clk_in) port_enable_in <= 1'b0;
		cyc(5);
		chk("port_off", {sclk_out, serial_data_oe_out, out_frame_sync_oe_out}, 3'h0);
		for (t = 0; t < 12000 && adc_ready_out !== 1'b0; t++) cyc(1);
		chk("fifo_full", adc_ready_out, 1'b0);
		chk("sclk_idle", sclk_out, 1'b0);
		@(posedge core_clk_in) port_enable_in <= 1'b1;
		wait_word;
		chk("first_word", host.rx_word, 16'hffff);
		chk("gain_kept", chan_gain_code_out, 18'h27a87);
		for (t = 0; t < 2000 && adc_ready_out !== 1'b1; t++) cyc(1);
		chk("fifo_drain", adc_ready_out, 1'b1);
	endtask
	initial begin
		cyc(16);
		@(posedge core_clk_in) rst_b_in <= 1'b1;
		cyc(2);
		chk("rst_state", {chan_gain_code_out, serial_data_oe_out, out_frame_sync_oe_out}, 0);
		@(posedge core_clk_in) port_enable_in <= 1'b1;
		t_gain;
		t_read;
		t_rate;
		t_disable;
		report_and_stop;
	end
	initial begin
		#600000;
		num_errors++;
		report_and_stop;
	end
endmodule // tb
